// ### logic/dic_top.sv
// dma interrupt control and channel sequencing, four byte channels
// assumes a classic wishbone master, same-clock dma side, chain pin async
//
// Behaviour
// - return vector on acknowledge, optional status bits
// - command code 000 changes nothing
// - codes 001/010/011 clear pending, service, both
// - codes 101/110/111 set them; 100 reserved
// - low four bits select channels, not stored
// - status shows service high nibble, pending low
// - acknowledge sets service flag of winner
// - winner needs pending, enable, chain, master, quiet
// - channel event sets its pending flag
// - request only if enabled, chained, not in service
// - enable bits 7:4 enable channel transfers
// - enable bits 3:0 enable abort interrupts
// - control bit 7 releases bus after every byte
// - control bits 5:4 choose service order
// - interrupt priority fixed rx a first
// - control bits 3:0 choose address step direction
// - four 16-bit byte counts, low and high
// - status codes 000, 100, 101, 110, 111
// - master enable clear suppresses every interrupt
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
module dic_top (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   input wire logic CHAIN_ENABLE_IN_I,
   input wire logic SERIAL_IRQ_I,
   input wire logic IACK_I,
   output logic [7:0] VEC_O,
   output logic VEC_VALID_O,
   output logic IRQ_O,
   input wire logic [3:0] DMA_REQ_I,
   input wire logic [3:0] ABORT_I,
   input wire logic BUS_GRANT_I,
   output logic BUS_REQ_O,
   output logic XFER_O,
   output logic [3:0] XFER_CH_O,
   output logic ADDR_UP_O
);
   // ***************************************
   // functions
   // ***************************************
   // {hit, two-bit channel index, high byte} of a count register address
   function automatic logic [3:0] cnt_dec(input logic [7:0] a);
      logic [7:0] d;
      logic hit;
      d = a - dic_pkg::OFS_CNT_FIRST;
      hit = (a >= dic_pkg::OFS_CNT_FIRST) && (a <= dic_pkg::OFS_CNT_LAST);
      cnt_dec = {hit, 2'h3 - d[4:3], d[2]};
   endfunction

   // fixed interrupt priority, bit 3 highest
   function automatic logic [3:0] top_one(input logic [3:0] v);
      top_one = 4'h0;
      if (v[3]) top_one = 4'h8;
      else if (v[2]) top_one = 4'h4;
      else if (v[1]) top_one = 4'h2;
      else if (v[0]) top_one = 4'h1;
   endfunction

   function automatic logic [2:0] vst(input logic [3:0] oh);
      unique case (oh)
         4'h8: vst = dic_pkg::VST_RXA;
         4'h4: vst = dic_pkg::VST_TXA;
         4'h2: vst = dic_pkg::VST_RXB;
         4'h1: vst = dic_pkg::VST_TXB;
         default: vst = dic_pkg::VST_NONE;
      endcase
   endfunction

   // ***************************************
   // declarations
   // ***************************************
   logic ack_ff;
   logic [31:0] dat_ff;
   logic [7:0] vec_ff;
   logic [7:0] ictl_ff;
   logic [7:0] den_ff;
   logic [7:0] dctl_ff;
   logic [3:0] pend_ff;
   logic [3:0] ius_ff;
   logic [3:0] tc_ff;
   logic [15:0] cnt_ff [4];
   logic [2:0] sync_ff;
   logic chain_ff;
   logic irq_ff;
   logic [7:0] vout_ff;
   logic vvalid_ff;
   dic_pkg::dic_state_e st_ff;
   logic bus_req_ff;
   logic xfer_ff;
   logic [3:0] xch_ff;
   logic up_ff;
   logic req;
   logic wr;
   logic [7:0] adr;
   logic [3:0] cdec;
   logic cmd_wr;
   logic [2:0] code;
   logic [3:0] csel;
   logic [3:0] clr_p;
   logic [3:0] clr_s;
   logic [3:0] set_p;
   logic [3:0] set_s;
   logic [3:0] hi_oh;
   logic hi_ok;
   logic xfer_now;
   logic [3:0] tc_hit;
   logic [3:0] cnt_wr;
   logic [3:0] hw_set;
   dic_arb_if arb_if ();

   dic_arb u_arb (
      .a(arb_if.arb)
   );

   // ***************************************
   // bus slave: one wait state, ack after one cycle
   // ***************************************
   assign req = CYC_I & STB_I & ~ack_ff;
   assign wr = req & WE_I & SEL_I[0];
   assign adr = {ADR_I[7:2], 2'h0};
   assign cdec = cnt_dec(adr);

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         dat_ff <= 32'h0000_0000;
      end else if (req) begin
         dat_ff <= 32'h0000_0000;
         if (cdec[3]) begin
            dat_ff[7:0] <= cdec[0] ? cnt_ff[cdec[2:1]][15:8] : cnt_ff[cdec[2:1]][7:0];
         end else begin
            unique case (adr)
               dic_pkg::OFS_VEC: dat_ff[7:0] <= vec_ff;
               dic_pkg::OFS_CMD: dat_ff[7:0] <= {ius_ff, pend_ff};
               dic_pkg::OFS_ICTL: dat_ff[7:0] <= ictl_ff;
               dic_pkg::OFS_DEN: dat_ff[7:0] <= den_ff;
               dic_pkg::OFS_DCTL: dat_ff[7:0] <= dctl_ff;
               dic_pkg::OFS_TC: dat_ff[3:0] <= tc_ff;
               default: dat_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign ACK_O = ack_ff;
   assign DAT_O = dat_ff;

   // ***************************************
   // control registers
   // ***************************************
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         vec_ff <= dic_pkg::RST_BYTE;
         ictl_ff <= dic_pkg::RST_BYTE;
         den_ff <= dic_pkg::RST_BYTE;
         dctl_ff <= dic_pkg::RST_BYTE;
      end else if (wr) begin
         if (adr == dic_pkg::OFS_VEC) vec_ff <= DAT_I[7:0];
         if (adr == dic_pkg::OFS_ICTL) ictl_ff <= DAT_I[7:0];
         if (adr == dic_pkg::OFS_DEN) den_ff <= DAT_I[7:0];
         if (adr == dic_pkg::OFS_DCTL) dctl_ff <= DAT_I[7:0];
      end
   end

   // ***************************************
   // interrupt command decode
   // ***************************************
   // bit 4 is ignored; selects act for this write only
   assign cmd_wr = wr && (adr == dic_pkg::OFS_CMD);
   assign code = DAT_I[dic_pkg::CMD_CODE_LO +: 3];
   assign csel = cmd_wr ? DAT_I[3:0] : 4'h0;
   assign clr_p = (code == dic_pkg::CMD_CLR_P || code == dic_pkg::CMD_CLR_B) ? csel : 4'h0;
   assign clr_s = (code == dic_pkg::CMD_CLR_S || code == dic_pkg::CMD_CLR_B) ? csel : 4'h0;
   assign set_p = (code == dic_pkg::CMD_SET_P || code == dic_pkg::CMD_SET_B) ? csel : 4'h0;
   assign set_s = (code == dic_pkg::CMD_SET_S || code == dic_pkg::CMD_SET_B) ? csel : 4'h0;
   // null and reserved codes fall through with all four masks zero

   // ***************************************
   // chain enable pin synchroniser
   // ***************************************
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         sync_ff <= 3'h0;
      end else begin
         sync_ff <= {sync_ff[1:0], CHAIN_ENABLE_IN_I};
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         chain_ff <= 1'b0;
      end else if (sync_ff[1] == sync_ff[2]) begin
         chain_ff <= sync_ff[2];
      end
   end

   // ***************************************
   // pending and in-service flags
   // ***************************************
   assign hi_oh = top_one(pend_ff & ictl_ff[3:0]);
   assign hi_ok = (hi_oh != 4'h0) && chain_ff && ictl_ff[dic_pkg::ICTL_MIE] && !SERIAL_IRQ_I;
   assign hw_set = tc_hit | (ABORT_I & den_ff[3:0]);

   // hardware set beats a same-cycle software clear
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         pend_ff <= dic_pkg::RST_FLAGS;
      end else begin
         pend_ff <= (pend_ff & ~clr_p) | set_p | hw_set;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         ius_ff <= dic_pkg::RST_FLAGS;
      end else begin
         ius_ff <= (ius_ff & ~clr_s) | set_s | ((IACK_I && hi_ok) ? hi_oh : 4'h0);
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= ictl_ff[dic_pkg::ICTL_MIE] && chain_ff
            && |(pend_ff & ictl_ff[3:0] & ~ius_ff);
      end
   end

   // ***************************************
   // vector return
   // ***************************************
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         vout_ff <= dic_pkg::RST_BYTE;
         vvalid_ff <= 1'b0;
      end else begin
         vvalid_ff <= IACK_I && hi_ok && !ictl_ff[dic_pkg::ICTL_NOVEC];
         if (IACK_I) begin
            vout_ff <= vec_ff;
            if (ictl_ff[dic_pkg::ICTL_INCL]) vout_ff[3:1] <= vst(hi_ok ? hi_oh : 4'h0);
         end
      end
   end

   assign IRQ_O = irq_ff;
   assign VEC_O = vout_ff;
   assign VEC_VALID_O = vvalid_ff;

   // ***************************************
   // transfer sequencing
   // ***************************************
   assign arb_if.elig = den_ff[7:4] & DMA_REQ_I & ~tc_ff;
   assign arb_if.order = dctl_ff[dic_pkg::DCTL_ORD_LO +: 2];
   assign xfer_now = (st_ff == dic_pkg::ST_XFER) && arb_if.any;

   // the gap state lets a serviced request drop before it is sampled again
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         st_ff <= dic_pkg::ST_IDLE;
         bus_req_ff <= 1'b0;
      end else begin
         unique case (st_ff)
            dic_pkg::ST_IDLE: begin
               if (arb_if.any) begin
                  st_ff <= dic_pkg::ST_REQ;
                  bus_req_ff <= 1'b1;
               end
            end
            dic_pkg::ST_REQ: begin
               if (BUS_GRANT_I) st_ff <= dic_pkg::ST_XFER;
            end
            dic_pkg::ST_XFER: begin
               st_ff <= dic_pkg::ST_GAP;
            end
            dic_pkg::ST_GAP: begin
               if (dctl_ff[dic_pkg::DCTL_PER_CH] || !arb_if.any) begin
                  st_ff <= dic_pkg::ST_IDLE;
                  bus_req_ff <= 1'b0;
               end else begin
                  st_ff <= dic_pkg::ST_XFER;
               end
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         xfer_ff <= 1'b0;
         xch_ff <= 4'h0;
         up_ff <= 1'b0;
      end else begin
         xfer_ff <= xfer_now;
         if (xfer_now) begin
            xch_ff <= arb_if.pick;
            up_ff <= |(arb_if.pick & dctl_ff[3:0]);
         end
      end
   end

   assign BUS_REQ_O = bus_req_ff;
   assign XFER_O = xfer_ff;
   assign XFER_CH_O = xch_ff;
   assign ADDR_UP_O = up_ff;

   // ***************************************
   // byte counts and terminal count
   // ***************************************
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         cnt_wr[b] = wr && cdec[3] && (cdec[2:1] == 2'(b));
         tc_hit[b] = xfer_now && arb_if.pick[b] && (cnt_ff[b] == dic_pkg::CNT_LAST_BYTE);
      end
   end

   // a bus write to a count byte wins over a same-cycle decrement
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         for (int b = 0; b < 4; b++) cnt_ff[b] <= dic_pkg::RST_CNT;
      end else begin
         for (int b = 0; b < 4; b++) begin
            if (cnt_wr[b]) begin
               if (cdec[0]) cnt_ff[b][15:8] <= DAT_I[7:0];
               else cnt_ff[b][7:0] <= DAT_I[7:0];
            end else if (xfer_now && arb_if.pick[b]) begin
               cnt_ff[b] <= cnt_ff[b] - 16'h0001;
            end
         end
      end
   end

   // terminal count parks the channel until its count is rewritten
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         tc_ff <= dic_pkg::RST_FLAGS;
      end else begin
         tc_ff <= (tc_ff & ~cnt_wr) | tc_hit;
      end
   end

   // ***************************************
   // assertions
   // ***************************************
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (RST_I);

   property p_null;
      cmd_wr && (code == dic_pkg::CMD_NULL) && !IACK_I |=> $stable(ius_ff);
   endproperty
   a_null: assert property (p_null) else $error("null command changed flags");

   property p_clr_s;
      cmd_wr && (code == dic_pkg::CMD_CLR_S) && !IACK_I |=> (ius_ff & $past(DAT_I[3:0])) == 4'h0;
   endproperty
   a_clr_s: assert property (p_clr_s) else $error("in-service not cleared");

   property p_set_p;
      cmd_wr && (code == dic_pkg::CMD_SET_P)
         |=> (pend_ff & $past(DAT_I[3:0])) == $past(DAT_I[3:0]);
   endproperty
   a_set_p: assert property (p_set_p) else $error("pending not set");

   property p_status;
      req && !WE_I && (adr == dic_pkg::OFS_CMD)
         |=> ACK_O && DAT_O[7:0] == $past({ius_ff, pend_ff});
   endproperty
   a_status: assert property (p_status) else $error("status read wrong");

   property p_iack;
      IACK_I && hi_ok |=> (ius_ff & $past(hi_oh)) == $past(hi_oh);
   endproperty
   a_iack: assert property (p_iack) else $error("winner not put in service");

   property p_vec;
      IACK_I && hi_ok && !ictl_ff[dic_pkg::ICTL_INCL] |=> VEC_O == $past(vec_ff);
   endproperty
   a_vec: assert property (p_vec) else $error("vector not returned");

   property p_mie;
      !ictl_ff[dic_pkg::ICTL_MIE] ##1 !ictl_ff[dic_pkg::ICTL_MIE] |-> !IRQ_O;
   endproperty
   a_mie: assert property (p_mie) else $error("interrupt while master disabled");

   property p_tc;
      tc_hit != 4'h0 |=> (pend_ff & $past(tc_hit)) == $past(tc_hit) && XFER_O;
   endproperty
   a_tc: assert property (p_tc) else $error("terminal count did not pend");

   property p_order;
      xfer_now && arb_if.order == 2'h0 && arb_if.elig[3] |=> XFER_CH_O == 4'h8;
   endproperty
   a_order: assert property (p_order) else $error("service order broken");

   property p_release;
      st_ff == dic_pkg::ST_GAP && dctl_ff[dic_pkg::DCTL_PER_CH] |=> !BUS_REQ_O ##1 !XFER_O;
   endproperty
   a_release: assert property (p_release) else $error("bus not released");
endmodule

// ### logic/dic_pkg.sv
// constants and types for the four-channel dma interrupt control block
// assumes a byte-wide register view on a 32-bit classic wishbone slave
package dic_pkg;
   // ***************************************
   // register byte offsets
   // ***************************************
   localparam logic [7:0] OFS_VEC = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_ICTL = 8'h08;
   localparam logic [7:0] OFS_DEN = 8'h0C;
   localparam logic [7:0] OFS_DCTL = 8'h10;
   localparam logic [7:0] OFS_CNT_FIRST = 8'h14;
   localparam logic [7:0] OFS_CNT_LAST = 8'h30;
   localparam logic [7:0] OFS_TC = 8'h34;
   // ***************************************
   // reset values and the last-byte count
   // ***************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_FLAGS = 4'h0;
   localparam logic [15:0] RST_CNT = 16'h0000;
   localparam logic [15:0] CNT_LAST_BYTE = 16'h0001;
   // ***************************************
   // field positions
   // ***************************************
   localparam int ICTL_MIE = 7;
   localparam int ICTL_NOVEC = 5;
   localparam int ICTL_INCL = 4;
   localparam int DCTL_PER_CH = 7;
   localparam int DCTL_ORD_LO = 4;
   localparam int CMD_CODE_LO = 5;
   // ***************************************
   // commands and vector status codes
   // ***************************************
   localparam logic [2:0] CMD_NULL = 3'h0;
   localparam logic [2:0] CMD_CLR_P = 3'h1;
   localparam logic [2:0] CMD_CLR_S = 3'h2;
   localparam logic [2:0] CMD_CLR_B = 3'h3;
   localparam logic [2:0] CMD_SET_P = 3'h5;
   localparam logic [2:0] CMD_SET_S = 3'h6;
   localparam logic [2:0] CMD_SET_B = 3'h7;
   localparam logic [2:0] VST_NONE = 3'h0;
   localparam logic [2:0] VST_RXA = 3'h4;
   localparam logic [2:0] VST_RXB = 3'h5;
   localparam logic [2:0] VST_TXA = 3'h6;
   localparam logic [2:0] VST_TXB = 3'h7;
   // ***************************************
   // service order tables, first served in bits 7:6
   // ***************************************
   localparam logic [7:0] ORD_0 = 8'hE4;
   localparam logic [7:0] ORD_1 = 8'h4E;
   localparam logic [7:0] ORD_2 = 8'hD8;
   localparam logic [7:0] ORD_3 = 8'h72;
   typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_XFER, ST_GAP} dic_state_e;
endpackage

// ### logic/dic_arb_if.sv
// carrier between the main block and its service-order arbiter
// assumes one-hot channel vectors, bit 3 receive a down to bit 0 transmit b
`timescale 1ns/10ps
interface dic_arb_if;
   logic [3:0] elig;
   logic [1:0] order;
   logic [3:0] pick;
   logic any;
   modport arb (input elig, input order, output pick, output any);
   modport user (output elig, output order, input pick, input any);
endinterface

// ### logic/dic_arb.sv
// service-order arbiter for simultaneous channel requests
// assumes requests already qualified by channel enable and terminal count
`timescale 1ns/10ps
module dic_arb (
   dic_arb_if.arb a
);
   logic [7:0] seq;
   // ***************************************
   // pick first eligible channel in programmed order
   // ***************************************
   always_comb begin
      unique case (a.order)
         2'h0: seq = dic_pkg::ORD_0;
         2'h1: seq = dic_pkg::ORD_1;
         2'h2: seq = dic_pkg::ORD_2;
         2'h3: seq = dic_pkg::ORD_3;
      endcase
      a.pick = 4'h0;
      for (int i = 3; i >= 0; i--) begin
         if (a.pick == 4'h0 && a.elig[seq[i*2 +: 2]]) begin
            a.pick[seq[i*2 +: 2]] = 1'b1;
         end
      end
      a.any = |a.elig;
   end
endmodule

// ### test/dic_far_model.sv
// far side model: four byte requesters and a bus arbiter
// assumes the block's clock; the bench arms requests with one-cycle pulses
`timescale 1ns/10ps
module dic_far_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] arm_i,
   input wire logic [1:0] lat_i,
   input wire logic bus_req_i,
   input wire logic xfer_i,
   input wire logic [3:0] xfer_ch_i,
   output logic bus_grant_o,
   output logic [3:0] dma_req_o
);
   // ***************
   // requesters
   // ***************
   logic [3:0] pend_ff;
   logic [1:0] wait_ff;
   // dropped in the byte's own cycle, else a second byte would follow
   assign dma_req_o = pend_ff & ~(xfer_i ? xfer_ch_i : 4'h0);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_ff <= 4'h0;
      end else begin
         pend_ff <= (pend_ff | arm_i) & ~(xfer_i ? xfer_ch_i : 4'h0);
      end
   end
   // ***************
   // arbiter: grant after a chosen wait, never without request
   // ***************
   always_ff @(posedge clk_i) begin
      if (rst_i || !bus_req_i) begin
         wait_ff <= 2'h0;
         bus_grant_o <= 1'b0;
      end else begin
         if (wait_ff != lat_i) wait_ff <= wait_ff + 2'h1;
         bus_grant_o <= (wait_ff == lat_i);
      end
   end
endmodule

// ### test/four_channel_dma_irq_control_bench.sv
// bench: register, command, interrupt and transfer sequences
// assumes dic_top and the far side model; one 250 MHz clock
`timescale 1ns/10ps
module four_channel_dma_irq_control_bench;
   logic clk, rst, cyc, stb, we, ack, chain, serial, iack, vec_v, irq, grant, breq, xfer, aup;
   logic breq_d;
   logic [7:0] adr, vec;
   logic [3:0] sel, dreq, abort, xch, arm;
   logic [31:0] wdat, rdat;
   logic [1:0] lat;
   int fails, comparisons, rises;
   dic_top u_dut (.REF_CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
      .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
      .CHAIN_ENABLE_IN_I(chain), .SERIAL_IRQ_I(serial), .IACK_I(iack), .VEC_O(vec),
      .VEC_VALID_O(vec_v), .IRQ_O(irq), .DMA_REQ_I(dreq), .ABORT_I(abort),
      .BUS_GRANT_I(grant), .BUS_REQ_O(breq), .XFER_O(xfer), .XFER_CH_O(xch),
      .ADDR_UP_O(aup));
   dic_far_model u_far (.clk_i(clk), .rst_i(rst), .arm_i(arm), .lat_i(lat),
      .bus_req_i(breq), .xfer_i(xfer), .xfer_ch_i(xch), .bus_grant_o(grant),
      .dma_req_o(dreq));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      breq_d <= breq;
      if (breq === 1'b1 && breq_d === 1'b0) rises <= rises + 1;
   end
   // ***************
   // tasks
   // ***************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic hang;
      fails++;
      give_verdict();
   endtask
   task automatic clk_n(input int n);
      repeat (n) @(posedge clk);
   endtask
   // no fixed latency assumed: wait for ack under a bound
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      sel <= 4'hF;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) hang();
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      check(what, q, exp);
      check("upper bytes", 32'(rdat[31:8]), 32'h0);
   endtask
   task automatic pulse_arm(input logic [3:0] m);
      @(posedge clk);
      arm <= m;
      @(posedge clk);
      arm <= 4'h0;
   endtask
   task automatic ack_irq(input logic exp_v);
      @(posedge clk);
      iack <= 1'b1;
      @(posedge clk);
      iack <= 1'b0;
      @(posedge clk);
      check("vec valid", vec_v, exp_v);
   endtask
   task automatic wait_xfer;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (xfer !== 1'b1 && n < 40);
      if (n >= 40) hang();
   endtask
   // all four ask at once; service order and bus holding per setting
   task automatic run(input logic [1:0] o);
      logic [15:0] seq;
      int k, r0;
      seq = (o == 2'h0) ? 16'h8421 : (o == 2'h1) ? 16'h2184 : (o == 2'h2) ? 16'h8241 : 16'h2814;
      lat <= o;
      for (k = 0; k < 8; k++) wr(dic_pkg::OFS_CNT_FIRST + 8'(k * 4), k[0] ? 8'h00 : 8'h02);
      wr(dic_pkg::OFS_DCTL, {o[0], 1'b0, o, 4'hA});
      pulse_arm(4'hF);
      clk_n(3);
      check("no enable", breq, 1'b0);
      r0 = rises;
      wr(dic_pkg::OFS_DEN, 8'hF0);
      for (k = 3; k >= 0; k--) begin
         wait_xfer();
         check("channel", xch, seq[4 * k +: 4]);
         check("step up", aup, |(seq[4 * k +: 4] & 4'hA));
      end
      clk_n(6);
      check("bus takes", 32'(rises - r0), o[0] ? 32'd4 : 32'd1);
      rd("count", dic_pkg::OFS_CNT_FIRST, 8'h01);
      wr(dic_pkg::OFS_DEN, 8'h00);
      $display("test order %0d done", o);
   endtask
   // ***************
   // sequence
   // ***************
   initial begin
      int i;
      logic [2:0] c;
      logic [7:0] m;
      rst = 1'b1;
      {cyc, stb, we, chain, serial, iack} = 6'h00;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0;
      abort = 4'h0;
      arm = 4'h0;
      lat = 2'h0;
      fails = 0;
      comparisons = 0;
      rises = 0;
      clk_n(3);
      rst <= 1'b0;
      chain <= 1'b1;
      rd("status", dic_pkg::OFS_CMD, 8'h00);
      rd("enable", dic_pkg::OFS_DEN, 8'h00);
      rd("unmapped", 8'h3C, 8'h00);
      wr(dic_pkg::OFS_VEC, 8'hF1);
      rd("vector", dic_pkg::OFS_VEC, 8'hF1);
      for (i = 0; i < 8; i++) wr(dic_pkg::OFS_CNT_FIRST + 8'(i * 4), 8'(i * 33 + 1));
      for (i = 0; i < 8; i++) begin
         rd("count", dic_pkg::OFS_CNT_FIRST + 8'(i * 4), 8'(i * 33 + 1));
      end
      $display("test registers done");
      for (i = 0; i < 8; i++) begin
         c = 3'(i);
         wr(dic_pkg::OFS_CMD, c[2] ? 8'h6F : 8'hEF);
         wr(dic_pkg::OFS_CMD, {c, 5'h05});
         m = {c[1] ? 4'h5 : 4'h0, c[0] ? 4'h5 : 4'h0};
         rd("command", dic_pkg::OFS_CMD, c[2] ? ((c == 3'h4) ? 8'h00 : m) : ~m);
      end
      wr(dic_pkg::OFS_CMD, 8'hA0);
      rd("no select", dic_pkg::OFS_CMD, 8'h55);
      wr(dic_pkg::OFS_CMD, 8'h6F);
      $display("test commands done");
      wr(dic_pkg::OFS_ICTL, 8'h9F);
      wr(dic_pkg::OFS_CMD, 8'hA5);
      clk_n(2);
      check("irq", irq, 1'b1);
      ack_irq(1'b1);
      check("vector", vec, 8'hFD);
      rd("status", dic_pkg::OFS_CMD, 8'h45);
      check("irq", irq, 1'b1);
      // tx a still pends and would win again: drop it so tx b wins
      wr(dic_pkg::OFS_CMD, 8'h24);
      ack_irq(1'b1);
      check("vector", vec, 8'hFF);
      clk_n(2);
      check("irq", irq, 1'b0);
      wr(dic_pkg::OFS_CMD, 8'h4F);
      wr(dic_pkg::OFS_ICTL, 8'h1F);
      clk_n(2);
      check("irq", irq, 1'b0);
      ack_irq(1'b0);
      wr(dic_pkg::OFS_ICTL, 8'h9F);
      serial <= 1'b1;
      ack_irq(1'b0);
      rd("status", dic_pkg::OFS_CMD, 8'h01);
      serial <= 1'b0;
      chain <= 1'b0;
      clk_n(8);
      check("irq", irq, 1'b0);
      ack_irq(1'b0);
      chain <= 1'b1;
      // plain vector, then the no-vector option
      wr(dic_pkg::OFS_ICTL, 8'h8F);
      clk_n(2);
      ack_irq(1'b1);
      check("plain vector", vec, 8'hF1);
      wr(dic_pkg::OFS_VEC, 8'h36);
      wr(dic_pkg::OFS_ICTL, 8'hAF);
      ack_irq(1'b0);
      check("no vector", vec, 8'h36);
      wr(dic_pkg::OFS_CMD, 8'h6F);
      wr(dic_pkg::OFS_DEN, 8'h04);
      @(posedge clk);
      abort <= 4'hC;
      @(posedge clk);
      abort <= 4'h0;
      rd("abort", dic_pkg::OFS_CMD, 8'h04);
      wr(dic_pkg::OFS_DEN, 8'h00);
      $display("test interrupts done");
      for (i = 0; i < 4; i++) run(2'(i));
      wr(dic_pkg::OFS_CMD, 8'h6F);
      wr(8'h2C, 8'h01);
      wr(8'h30, 8'h00);
      pulse_arm(4'h1);
      wr(dic_pkg::OFS_DEN, 8'h10);
      wait_xfer();
      clk_n(4);
      rd("terminal", dic_pkg::OFS_TC, 8'h01);
      rd("status", dic_pkg::OFS_CMD, 8'h01);
      pulse_arm(4'h1);
      clk_n(10);
      check("no serve", breq, 1'b0);
      $display("test terminal done");
      give_verdict();
   end
endmodule
